// ### logic/rtc_pkg.sv
/*
 * Shared constants of the time-keeping and interrupt-status block: register offsets,
 * field positions, reset values, BCD limits and interrupt pulse timing.
 * Assumes a 200 MHz system clock; nothing else is needed to compile it.
 */
package rtc_pkg;
    localparam logic [7:0] ADDR_CTRL2 = 8'h01;
    localparam logic [7:0] ADDR_SEC = 8'h02;
    localparam logic [7:0] ADDR_MIN = 8'h03;
    localparam logic [7:0] ADDR_HOUR = 8'h04;
    localparam logic [7:0] ADDR_DAY = 8'h05;
    localparam int BIT_TIE = 0;
    localparam int BIT_AIE = 1;
    localparam int BIT_TF = 2;
    localparam int BIT_AF = 3;
    localparam int BIT_PSEL = 4;
    localparam int BIT_VL = 7;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic VL_RST = 1'b1;
    localparam logic [7:0] TIME_RST = 8'h00;
    localparam logic [7:0] DAY_RST = 8'h01;
    localparam logic [7:0] SEC_MAX = 8'h59;
    localparam logic [7:0] MIN_MAX = 8'h59;
    localparam logic [7:0] HOUR_MAX = 8'h23;
    localparam logic [7:0] DAY_MAX_31 = 8'h31;
    localparam logic [7:0] DAY_MAX_30 = 8'h30;
    localparam logic [7:0] DAY_MAX_FEB = 8'h28;
    localparam logic [7:0] DAY_MAX_LEAP = 8'h29;
    localparam logic [7:0] SEC_MASK = 8'h7F;
    localparam logic [7:0] MIN_MASK = 8'h7F;
    localparam logic [7:0] HOUR_MASK = 8'h3F;
    localparam logic [7:0] DAY_MASK = 8'h3F;
    localparam logic [4:0] MONTH_FEB = 5'h02;
    localparam int unsigned SYS_CLK_HZ = 200000000;
    localparam int unsigned INT_DEN_8192 = 8192;
    localparam int unsigned INT_DEN_4096 = 4096;
    localparam int unsigned INT_DEN_128 = 128;
    localparam int unsigned INT_DEN_64 = 64;
    localparam int PULSE_CNT_W = 22;
    typedef enum logic [1:0] {SRC_4096, SRC_64, SRC_1, SRC_1_60} timer_src_e;
endpackage

// ### logic/rtc_bcd_counter.sv
/*
 * One two-digit BCD time counter with load, wrap to a minimum and carry out.
 * Assumes tick and load come from logic on the same clock as i_clk.
 */
`timescale 1ns/1ps
module rtc_bcd_counter #(
    parameter logic [7:0] P_RST_VAL = 8'h00
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_tick,
    input wire logic i_load,
    input wire logic [7:0] i_load_val,
    input wire logic [7:0] i_min,
    input wire logic [7:0] i_max,
    output logic [7:0] o_value,
    output logic o_carry
);
    logic [7:0] value_r;

    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        if (v[3:0] >= 4'h9) begin
            bcd_inc = {v[7:4] + 4'h1, 4'h0};
        end else begin
            bcd_inc = {v[7:4], v[3:0] + 4'h1};
        end
    endfunction

    // BCD order matches numeric order, so a plain compare finds the end of range.
    assign o_carry = i_tick && (value_r >= i_max); // see R19

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            value_r <= P_RST_VAL;
        end else if (i_load) begin
            value_r <= i_load_val;
        end else if (o_carry) begin
            value_r <= i_min; // see R19 see R20
        end else if (i_tick) begin
            value_r <= bcd_inc(value_r);
        end
    end

    assign o_value = value_r;
endmodule

// ### logic/rtc_time_irq.sv
/*
 * Interrupt status/control and seconds-to-days time keeping of a real time clock.
 * Register requests arrive on the link clock from the serial bus front end; the
 * time counters and flags run on the system clock. Alarm, timer, tick and month/year
 * inputs come from logic on the system clock.
 */
// Summary of operation
// R1: An alarm event sets the alarm flag, bit 3 of the control/status register.
// R2: A finished countdown sets the timer flag, bit 2 of that register.
// R3: Flags hold until written; a write ANDs data with the flag.
// R4: Interrupt is alarm flag and enable at bit 1, OR timer flag and bit 0.
// R5: With pulse select at bit 4 low, timer interrupt follows the timer flag.
// R6: With pulse select high, timer interrupt is a pulse sized by source and count.
// R7: In pulsed mode an enabled alarm flag holds the interrupt permanently active.
// R8: Timer flag and interrupt go active in the same cycle.
// R9: Bits 7 to 5 of the control/status register read as zero.
// R10: Master reads both flags to find which source interrupted.
// R11: Seconds bit 7 flags the time as no longer trustworthy.
// R12: Seconds register bits 6 to 0 hold BCD seconds 00 to 59.
// R13: Minutes register bits 6 to 0 hold BCD minutes 00 to 59.
// R14: Hours register bits 5 to 0 hold BCD hours 00 to 23.
// R15: Days register bits 5 to 0 hold BCD day of month 01 to 31.
// R16: February has 29 days when the year is divisible by four, 00 included.
// R17: A countdown value of zero means the timer is stopped.
// R18: The year input is BCD 00 to 99.
// R19: Each counter wraps to its minimum and carries into the next.
// R20: Days wrap after 28, 29, 30 or 31 by month length.
`timescale 1ns/1ps
module rtc_time_irq #(
    parameter logic [21:0] P_W8192_CYC = 22'(rtc_pkg::SYS_CLK_HZ / rtc_pkg::INT_DEN_8192),
    parameter logic [21:0] P_W4096_CYC = 22'(rtc_pkg::SYS_CLK_HZ / rtc_pkg::INT_DEN_4096),
    parameter logic [21:0] P_W128_CYC = 22'(rtc_pkg::SYS_CLK_HZ / rtc_pkg::INT_DEN_128),
    parameter logic [21:0] P_W64_CYC = 22'(rtc_pkg::SYS_CLK_HZ / rtc_pkg::INT_DEN_64)
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_link_clk,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    output logic o_reg_busy,
    output logic [7:0] o_reg_rdata,
    output logic o_reg_rdata_valid,
    input wire logic i_second_tick,
    input wire logic i_alarm_event,
    input wire logic i_timer_event,
    input wire logic [7:0] i_timer_count,
    input wire logic [1:0] i_timer_src,
    input wire logic [4:0] i_month_bcd,
    input wire logic [7:0] i_year_bcd,
    input wire logic i_integrity_fail,
    output logic o_int_out,
    output logic o_int_oe,
    output logic o_day_carry
);
    logic rst_meta_r, rst_sys_n;
    logic lrst_meta_r, rst_link_n;
    logic busy_r, req_wr_r, req_tgl_r, rvalid_r;
    logic [7:0] req_addr_r, req_data_r, rdata_r;
    logic [2:0] ack_sync_r, req_sync_r;
    logic ack_lvl_r, req_lvl_r, ack_evt, req_evt;
    logic ack_tgl_r;
    logic [7:0] rd_data_r;
    logic wr_stb, rd_stb;
    logic af_r, tf_r, psel_r, aie_r, tie_r, vl_r;
    logic af_nxt, tf_nxt, timer_fire, int_nxt;
    logic [21:0] pulse_r, pulse_nxt;
    logic int_oe_r, int_out_r, day_carry_r;
    logic [7:0] cnt_val [4];
    logic [7:0] cnt_max [4];
    logic [7:0] cnt_min [4];
    logic [7:0] cnt_mask [4];
    logic [3:0] cnt_tick, cnt_carry, cnt_load;

    function automatic logic is_leap(input logic [7:0] y);
        is_leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                       : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
    endfunction

    function automatic logic [7:0] month_len(input logic [4:0] m, input logic [7:0] y);
        if (m == rtc_pkg::MONTH_FEB) begin
            month_len = is_leap(y) ? rtc_pkg::DAY_MAX_LEAP : rtc_pkg::DAY_MAX_FEB;
        end else if (m == 5'h04 || m == 5'h06 || m == 5'h09 || m == 5'h11) begin
            month_len = rtc_pkg::DAY_MAX_30;
        end else begin
            month_len = rtc_pkg::DAY_MAX_31;
        end
    endfunction

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_meta_r <= 1'b0;
            rst_sys_n <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sys_n <= rst_meta_r;
        end
    end

    always_ff @(posedge i_link_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            lrst_meta_r <= 1'b0;
            rst_link_n <= 1'b0;
        end else begin
            lrst_meta_r <= 1'b1;
            rst_link_n <= lrst_meta_r;
        end
    end

    // Request side on the link clock. Address and data stay frozen while busy, so the
    // system side may sample them once the toggle has crossed.
    always_ff @(posedge i_link_clk or negedge rst_link_n) begin
        if (!rst_link_n) begin
            busy_r <= 1'b0;
            req_wr_r <= 1'b0;
            req_tgl_r <= 1'b0;
            req_addr_r <= 8'h00;
            req_data_r <= 8'h00;
        end else if (!busy_r && (i_reg_wr || i_reg_rd)) begin
            busy_r <= 1'b1;
            req_wr_r <= i_reg_wr;
            req_tgl_r <= ~req_tgl_r;
            req_addr_r <= i_reg_addr;
            req_data_r <= i_reg_wdata;
        end else if (ack_evt) begin
            busy_r <= 1'b0;
        end
    end

    always_ff @(posedge i_link_clk or negedge rst_link_n) begin
        if (!rst_link_n) begin
            ack_sync_r <= 3'h0;
            ack_lvl_r <= 1'b0;
        end else begin
            ack_sync_r <= {ack_sync_r[1:0], ack_tgl_r};
            if (ack_sync_r[1] == ack_sync_r[2]) begin
                ack_lvl_r <= ack_sync_r[2];
            end
        end
    end

    assign ack_evt = (ack_sync_r[1] == ack_sync_r[2]) && (ack_sync_r[2] != ack_lvl_r);

    always_ff @(posedge i_link_clk or negedge rst_link_n) begin
        if (!rst_link_n) begin
            rvalid_r <= 1'b0;
            rdata_r <= 8'h00;
        end else begin
            rvalid_r <= ack_evt && !req_wr_r;
            if (ack_evt && !req_wr_r) begin
                rdata_r <= rd_data_r;
            end
        end
    end

    assign o_reg_busy = busy_r;
    assign o_reg_rdata = rdata_r;
    assign o_reg_rdata_valid = rvalid_r;

    always_ff @(posedge i_sys_clk or negedge rst_sys_n) begin
        if (!rst_sys_n) begin
            req_sync_r <= 3'h0;
            req_lvl_r <= 1'b0;
        end else begin
            req_sync_r <= {req_sync_r[1:0], req_tgl_r};
            if (req_sync_r[1] == req_sync_r[2]) begin
                req_lvl_r <= req_sync_r[2];
            end
        end
    end

    assign req_evt = (req_sync_r[1] == req_sync_r[2]) && (req_sync_r[2] != req_lvl_r);
    assign wr_stb = req_evt && req_wr_r;
    assign rd_stb = req_evt && !req_wr_r;

    always_ff @(posedge i_sys_clk or negedge rst_sys_n) begin
        if (!rst_sys_n) begin
            ack_tgl_r <= 1'b0;
            rd_data_r <= 8'h00;
        end else if (req_evt) begin
            ack_tgl_r <= ~ack_tgl_r;
            if (req_addr_r == rtc_pkg::ADDR_CTRL2) begin
                rd_data_r <= {3'h0, psel_r, af_r, tf_r, aie_r, tie_r}; // see R9 see R10
            end else if (req_addr_r == rtc_pkg::ADDR_SEC) begin
                rd_data_r <= {vl_r, cnt_val[0][6:0]}; // see R11 see R12
            end else if (req_addr_r == rtc_pkg::ADDR_MIN) begin
                rd_data_r <= {1'b0, cnt_val[1][6:0]}; // see R13
            end else if (req_addr_r == rtc_pkg::ADDR_HOUR) begin
                rd_data_r <= {2'h0, cnt_val[2][5:0]}; // see R14
            end else if (req_addr_r == rtc_pkg::ADDR_DAY) begin
                rd_data_r <= {2'h0, cnt_val[3][5:0]}; // see R15
            end else begin
                rd_data_r <= 8'h00;
            end
        end
    end

    // A flag that is raised in the same cycle as a clearing write stays set.
    assign timer_fire = i_timer_event && (i_timer_count != 8'h00); // see R17
    assign af_nxt = (af_r && !(wr_stb && req_addr_r == rtc_pkg::ADDR_CTRL2
                                && !req_data_r[rtc_pkg::BIT_AF])) || i_alarm_event; // see R1 see R3
    assign tf_nxt = (tf_r && !(wr_stb && req_addr_r == rtc_pkg::ADDR_CTRL2
                                && !req_data_r[rtc_pkg::BIT_TF])) || timer_fire; // see R2 see R3

    always_ff @(posedge i_sys_clk or negedge rst_sys_n) begin
        if (!rst_sys_n) begin
            af_r <= rtc_pkg::CTRL_RST[rtc_pkg::BIT_AF];
            tf_r <= rtc_pkg::CTRL_RST[rtc_pkg::BIT_TF];
        end else begin
            af_r <= af_nxt;
            tf_r <= tf_nxt;
        end
    end

    always_ff @(posedge i_sys_clk or negedge rst_sys_n) begin
        if (!rst_sys_n) begin
            psel_r <= rtc_pkg::CTRL_RST[rtc_pkg::BIT_PSEL];
            aie_r <= rtc_pkg::CTRL_RST[rtc_pkg::BIT_AIE];
            tie_r <= rtc_pkg::CTRL_RST[rtc_pkg::BIT_TIE];
        end else if (wr_stb && req_addr_r == rtc_pkg::ADDR_CTRL2) begin
            psel_r <= req_data_r[rtc_pkg::BIT_PSEL];
            aie_r <= req_data_r[rtc_pkg::BIT_AIE];
            tie_r <= req_data_r[rtc_pkg::BIT_TIE];
        end
    end

    always_ff @(posedge i_sys_clk or negedge rst_sys_n) begin
        if (!rst_sys_n) begin
            vl_r <= rtc_pkg::VL_RST;
        end else if (i_integrity_fail) begin
            vl_r <= 1'b1; // see R11
        end else if (wr_stb && req_addr_r == rtc_pkg::ADDR_SEC) begin
            vl_r <= req_data_r[rtc_pkg::BIT_VL];
        end
    end

    // The pulse is timed on the system clock; a new countdown restarts it.
    always_comb begin
        pulse_nxt = (pulse_r != 22'h000000) ? pulse_r - 22'h000001 : 22'h000000;
        if (timer_fire) begin
            case (rtc_pkg::timer_src_e'(i_timer_src))
                rtc_pkg::SRC_4096: begin
                    pulse_nxt = (i_timer_count == 8'h01) ? P_W8192_CYC : P_W4096_CYC; // see R6
                end
                rtc_pkg::SRC_64: begin
                    pulse_nxt = (i_timer_count == 8'h01) ? P_W128_CYC : P_W64_CYC; // see R6
                end
                default: begin
                    pulse_nxt = P_W64_CYC; // see R6
                end
            endcase
        end
    end

    always_ff @(posedge i_sys_clk or negedge rst_sys_n) begin
        if (!rst_sys_n) begin
            pulse_r <= 22'h000000;
        end else begin
            pulse_r <= pulse_nxt;
        end
    end

    // Built from next-state flag values so the pin moves with the flag.
    assign int_nxt = (af_nxt && aie_r) // see R4 see R7
        || (tie_r && (psel_r ? (pulse_nxt != 22'h000000) : tf_nxt)); // see R5 see R6 see R8

    always_ff @(posedge i_sys_clk or negedge rst_sys_n) begin
        if (!rst_sys_n) begin
            int_oe_r <= 1'b0;
            int_out_r <= 1'b0;
            day_carry_r <= 1'b0;
        end else begin
            int_oe_r <= int_nxt;
            int_out_r <= 1'b0;
            day_carry_r <= cnt_carry[3];
        end
    end

    assign o_int_oe = int_oe_r;
    assign o_int_out = int_out_r;
    assign o_day_carry = day_carry_r;

    always_comb begin
        cnt_max[0] = rtc_pkg::SEC_MAX; // see R12
        cnt_max[1] = rtc_pkg::MIN_MAX; // see R13
        cnt_max[2] = rtc_pkg::HOUR_MAX; // see R14
        cnt_max[3] = month_len(i_month_bcd, i_year_bcd); // see R16 see R18 see R20
        cnt_min[0] = rtc_pkg::TIME_RST;
        cnt_min[1] = rtc_pkg::TIME_RST;
        cnt_min[2] = rtc_pkg::TIME_RST;
        cnt_min[3] = rtc_pkg::DAY_RST; // see R15
        cnt_mask[0] = rtc_pkg::SEC_MASK;
        cnt_mask[1] = rtc_pkg::MIN_MASK;
        cnt_mask[2] = rtc_pkg::HOUR_MASK;
        cnt_mask[3] = rtc_pkg::DAY_MASK;
    end

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_cnt
            assign cnt_tick[gi] = (gi == 0) ? i_second_tick : cnt_carry[(gi + 3) % 4]; // see R19
            assign cnt_load[gi] = wr_stb && (req_addr_r == rtc_pkg::ADDR_SEC + 8'(gi));
            rtc_bcd_counter #(
                .P_RST_VAL((gi == 3) ? rtc_pkg::DAY_RST : rtc_pkg::TIME_RST)
            ) u_cnt (
                .i_clk(i_sys_clk),
                .i_rst_n(rst_sys_n),
                .i_tick(cnt_tick[gi]),
                .i_load(cnt_load[gi]),
                .i_load_val(req_data_r & cnt_mask[gi]),
                .i_min(cnt_min[gi]),
                .i_max(cnt_max[gi]),
                .o_value(cnt_val[gi]),
                .o_carry(cnt_carry[gi])
            );
        end
    endgenerate

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!rst_sys_n);

    a_alarm_sets: assert property (i_alarm_event |=> af_r) else $error("alarm flag not set"); // see R1
    a_timer_sets: assert property (timer_fire |=> tf_r && (int_oe_r || !$past(tie_r))) // see R2
        else $error("timer flag not set");
    a_flag_and_clear: assert property (wr_stb && req_addr_r == rtc_pkg::ADDR_CTRL2 // see R3
        && !req_data_r[rtc_pkg::BIT_AF] && !i_alarm_event |=> !af_r)
        else $error("alarm flag not cleared by zero write");
    a_flag_keep: assert property (tf_r && !(wr_stb && req_addr_r == rtc_pkg::ADDR_CTRL2) // see R3
        |=> tf_r) else $error("timer flag lost without write");
    a_alarm_hold: assert property (af_r && aie_r && $stable(aie_r) |-> int_oe_r) // see R4
        else $error("enabled alarm flag not driving interrupt");
    a_level_mode: assert property (!psel_r && tie_r && $stable({psel_r, tie_r}) // see R5
        |-> int_oe_r == (tf_r || (af_r && aie_r))) else $error("level interrupt mismatch");
    a_pulse_load: assert property (timer_fire && i_timer_src == 2'h0 // see R6
        && i_timer_count == 8'h01 |=> pulse_r == P_W8192_CYC) else $error("pulse width wrong");
    a_pulse_count: assert property (pulse_r != 22'h000000 && !timer_fire // see R6
        |=> pulse_r == $past(pulse_r) - 22'h000001) else $error("pulse not counting down");
    a_flag_irq_same: assert property (timer_fire && tie_r && !$past(tf_r) // see R8
        ##1 $stable(tie_r) |-> tf_r && int_oe_r) else $error("flag and interrupt not together");
    a_stopped_timer: assert property (i_timer_event && i_timer_count == 8'h00 // see R17
        && !tf_r && !wr_stb |=> !tf_r) else $error("stopped timer set its flag");
    a_reserved_zero: assert property (rd_stb && req_addr_r == rtc_pkg::ADDR_CTRL2 // see R9
        |=> rd_data_r[7:5] == 3'h0) else $error("reserved bits not zero");
    a_vl_set: assert property (i_integrity_fail |=> vl_r ##1 vl_r || $past(wr_stb)) // see R11
        else $error("integrity flag not set");
    a_sec_wrap: assert property (cnt_carry[0] && !cnt_load[0] // see R12 see R19
        |=> cnt_val[0] == rtc_pkg::TIME_RST && cnt_tick[1] == 1'b0)
        else $error("seconds did not wrap");
    a_feb_leap: assert property (cnt_tick[3] && !cnt_load[3] && is_leap(i_year_bcd) // see R16
        && i_month_bcd == rtc_pkg::MONTH_FEB && cnt_val[3] == rtc_pkg::DAY_MAX_FEB
        |=> cnt_val[3] == rtc_pkg::DAY_MAX_LEAP) else $error("leap day skipped in february");
    a_day_min: assert property (cnt_carry[3] && !cnt_load[3] // see R15 see R20
        |=> cnt_val[3] == rtc_pkg::DAY_RST) else $error("day did not wrap to one");

    c_alarm_irq: cover property (i_alarm_event && aie_r ##1 int_oe_r);
    c_pulse_end: cover property (psel_r && pulse_r == 22'h000001 ##1 pulse_r == 22'h000000);
    c_flag_clear: cover property (af_r && wr_stb && req_addr_r == rtc_pkg::ADDR_CTRL2 ##1 !af_r);
    c_day_roll: cover property (cnt_carry[3]);
endmodule

// ### verification/rtc_reg_master.sv
/*
 * Model of the bus master that reaches the registers over the link register port.
 * Assumes i_link_clk is free running and that the caller waits out reset first.
 */
`timescale 1ns/1ps
module rtc_reg_master (
    input wire logic i_link_clk,
    input wire logic i_reg_busy,
    input wire logic [7:0] i_reg_rdata,
    input wire logic i_reg_rdata_valid,
    output logic o_reg_wr,
    output logic o_reg_rd,
    output logic [7:0] o_reg_addr,
    output logic [7:0] o_reg_wdata
);
    initial begin
        o_reg_wr = 1'b0;
        o_reg_rd = 1'b0;
        o_reg_addr = 8'h00;
        o_reg_wdata = 8'h00;
    end
    // One request at a time; it is held over the edge that takes it, then released.
    task automatic xfer(input logic wr, input logic [7:0] addr, input logic [7:0] wdata,
                        output logic [7:0] rdata, output logic ok);
        logic seen;
        int n;
        seen = 1'b0;
        ok = 1'b0;
        rdata = 8'h00;
        @(negedge i_link_clk);
        o_reg_wr = wr;
        o_reg_rd = !wr;
        o_reg_addr = addr;
        o_reg_wdata = wdata;
        @(negedge i_link_clk);
        o_reg_wr = 1'b0;
        o_reg_rd = 1'b0;
        // Released lines carry the inverse so that a stale value cannot pass as live.
        o_reg_addr = ~addr;
        o_reg_wdata = ~wdata;
        for (n = 0; n < 40 && !ok; n++) begin
            seen = seen | (i_reg_busy === 1'b1);
            if (seen && i_reg_busy === 1'b0) begin
                ok = wr || (i_reg_rdata_valid === 1'b1);
                rdata = i_reg_rdata;
                n = 40;
            end else begin
                @(negedge i_link_clk);
            end
        end
    endtask
endmodule

// ### verification/tb_top.sv
/*
 * Self-checking bench of the interrupt status and time keeping block.
 * Assumes the register master model drives the link port and the bench all else.
 */
`timescale 1ns/1ps
module tb_top;
    localparam int W1 = 4;
    localparam int W2 = 8;
    localparam int W3 = 12;
    localparam int W4 = 16;
    logic sys_clk, link_clk, rst_n, reg_wr, reg_rd, reg_busy, rdata_valid;
    logic int_out, int_oe, day_carry;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, t_count, year;
    logic [1:0] t_src;
    logic [4:0] month;
    logic [3:0] ev;
    int n_fail = 0;
    int checks = 0;
    int p_src[6] = '{0, 0, 1, 1, 2, 3};
    logic [7:0] p_n[6] = '{8'h01, 8'h05, 8'h01, 8'h05, 8'h01, 8'h05};
    int p_w[6] = '{W1, W2, W3, W4, W4, W4};
    logic [7:0] d_mon[6] = '{8'h02, 8'h02, 8'h02, 8'h04, 8'h01, 8'h02};
    logic [7:0] d_yr[6] = '{8'h04, 8'h03, 8'h00, 8'h11, 8'h11, 8'h96};
    logic [7:0] d_day[6] = '{8'h28, 8'h28, 8'h28, 8'h30, 8'h31, 8'h29};
    logic [7:0] d_exp[6] = '{8'h29, 8'h01, 8'h29, 8'h01, 8'h01, 8'h01};
    rtc_time_irq #(.P_W8192_CYC(22'(W1)), .P_W4096_CYC(22'(W2)), .P_W128_CYC(22'(W3)),
        .P_W64_CYC(22'(W4))) u_dut (.i_sys_clk(sys_clk), .i_rst_n(rst_n),
        .i_link_clk(link_clk), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .i_reg_addr(reg_addr),
        .i_reg_wdata(reg_wdata), .o_reg_busy(reg_busy), .o_reg_rdata(reg_rdata),
        .o_reg_rdata_valid(rdata_valid), .i_second_tick(ev[0]), .i_alarm_event(ev[1]),
        .i_timer_event(ev[2]), .i_timer_count(t_count), .i_timer_src(t_src),
        .i_month_bcd(month), .i_year_bcd(year), .i_integrity_fail(ev[3]),
        .o_int_out(int_out), .o_int_oe(int_oe), .o_day_carry(day_carry));
    rtc_reg_master u_master (.i_link_clk(link_clk), .i_reg_busy(reg_busy),
        .i_reg_rdata(reg_rdata), .i_reg_rdata_valid(rdata_valid), .o_reg_wr(reg_wr),
        .o_reg_rd(reg_rd), .o_reg_addr(reg_addr), .o_reg_wdata(reg_wdata));
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    initial begin
        link_clk = 1'b0;
        #3.7;
        forever #6 link_clk = ~link_clk;
    end
    function automatic logic [7:0] to_bcd(input int v);
        return 8'((v / 10) * 16 + v % 10);
    endfunction
    task automatic end_of_test;
        if (n_fail == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] r;
        logic ok;
        u_master.xfer(1'b1, a, d, r, ok);
        chk("write answer", 8'h01, {7'h00, ok});
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] r;
        logic ok;
        u_master.xfer(1'b0, a, 8'h00, r, ok);
        chk("read answer", 8'h01, {7'h00, ok});
        chk($sformatf("register %h", a), exp, r);
    endtask
    // Returns at the falling edge after the edge that took the event.
    task automatic pulse(input logic [3:0] k);
        @(negedge sys_clk);
        ev = k;
        @(negedge sys_clk);
        ev = 4'h0;
    endtask
    task automatic oe_count(input int exp);
        int c;
        c = 0;
        repeat (40) begin
            c += int'(int_oe === 1'b1);
            @(negedge sys_clk);
        end
        chk("interrupt active cycles", 8'(exp), 8'(c));
        chk("interrupt pin data", 8'h00, {7'h00, int_out});
    endtask
    initial begin
        #200000;
        n_fail++;
        end_of_test();
    end
    initial begin
        int s;
        rst_n = 1'b0;
        ev = 4'h0;
        t_count = 8'h01;
        t_src = 2'd0;
        month = 5'h01;
        year = 8'h00;
        void'($urandom(76));
        repeat (2) @(negedge sys_clk);
        rst_n = 1'b1;
        repeat (4) @(posedge link_clk);
        rd(8'h01, 8'h00);
        rd(8'h02, 8'h80);
        rd(8'h03, 8'h00);
        rd(8'h04, 8'h00);
        rd(8'h05, 8'h01);
        rd(8'h06, 8'h00);
        for (int i = 0; i < 6; i++) begin
            month = d_mon[i][4:0];
            year = d_yr[i];
            wr(8'h05, d_day[i]);
            wr(8'h04, 8'h23);
            wr(8'h03, 8'h59);
            wr(8'h02, 8'h59);
            pulse(4'h1);
            chk("day carry", {7'h00, d_exp[i] == 8'h01}, {7'h00, day_carry});
            rd(8'h05, d_exp[i]);
            rd(8'h04, 8'h00);
            rd(8'h03, 8'h00);
            rd(8'h02, 8'h00);
        end
        repeat (8) begin
            s = int'($urandom_range(0, 58));
            wr(8'h02, to_bcd(s));
            pulse(4'h1);
            rd(8'h02, to_bcd(s + 1));
        end
        wr(8'h02, 8'h00);
        pulse(4'h8);
        rd(8'h02, 8'h80);
        t_count = 8'h00;
        pulse(4'h4);
        rd(8'h01, 8'h00);
        t_count = 8'h03;
        pulse(4'h4);
        chk("interrupt disabled", 8'h00, {7'h00, int_oe});
        pulse(4'h2);
        rd(8'h01, 8'h0C);
        wr(8'h01, 8'h08);
        rd(8'h01, 8'h08);
        wr(8'h01, 8'h01);
        rd(8'h01, 8'h01);
        pulse(4'h4);
        chk("interrupt with timer flag", 8'h01, {7'h00, int_oe});
        rd(8'h01, 8'h05);
        wr(8'h01, 8'h01);
        chk("interrupt after clear", 8'h00, {7'h00, int_oe});
        wr(8'h01, 8'h02);
        pulse(4'h2);
        chk("interrupt with alarm flag", 8'h01, {7'h00, int_oe});
        wr(8'h01, 8'h1A);
        oe_count(40);
        for (int i = 0; i < 6; i++) begin
            t_src = 2'(p_src[i]);
            t_count = p_n[i];
            wr(8'h01, 8'h11);
            pulse(4'h4);
            oe_count(p_w[i]);
        end
        end_of_test();
    end
endmodule
